// file: option_cfg.svh
// Constants for the option decoder: addresses, bit positions, reset values
`ifndef OPTION_CFG_SVH
`define OPTION_CFG_SVH

// ----------------------------------------
// Programmer address map
// ----------------------------------------
`define OPT_FIRST_ADDR 15'h3FF0
`define OPT_LAST_ADDR 15'h3FF5
`define OPT_COUNT 3'h6
`define PROG_WIN_LO 15'h4000
`define PROG_WIN_HI 15'h7FFF
`define CPU_WIN_BASE 16'hC000

// ----------------------------------------
// First option byte fields
// ----------------------------------------
`define OPT0_POR_BIT 0
`define OPT0_DUAL_BIT 1
`define OPT0_RSTOUT_BIT 2
`define OPT0_SETTLE_LO_BIT 4
`define OPT0_SETTLE_HI_BIT 5
`define OPT_ERASED 8'hFF

// ----------------------------------------
// AXI4-Lite register offsets
// ----------------------------------------
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_OPT0 12'h008
`define REG_OPT1 12'h00C
`define REG_OPT2 12'h010
`define REG_OPT3 12'h014
`define REG_OPT4 12'h018
`define REG_OPT5 12'h01C
`define CTRL_RESET 1'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: option_pkg.sv
// Types shared by the option decoder
package option_pkg;

    typedef struct packed {
        logic por_enable;
        logic dual_clock;
        logic reset_pin_drive;
        logic [1:0] osc_settle_sel;
        logic [7:0] port0_pullup_n;
        logic [7:0] port1_pullup_n;
        logic [7:0] port5_pullup_n;
    } option_cfg_t;

    typedef struct packed {
        logic valid;
        logic [14:0] addr;
    } prom_req_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LOAD = 3'b010,
        ST_DONE = 3'b100
    } load_state_t;

endpackage : option_pkg

// file: otprom_option_decoder.sv
// Option byte loader, decoder, address mapper and AXI4-Lite status port
// Operation
// R1: Options sit in six bytes from 3FF0H through 3FF5H of the programmer space.
// R2: EPROM mode maps CPU C000H-FFFFH onto programmer 4000H-7FFFH.
// R3: Byte 0 bit 0 enables power-on reset; bits 5:4 pick settle time.
// R4: Byte 0 bit 1 one selects dual clock, zero single clock.
// R5: Byte 0 bit 2 one lets internal resets drive the reset pin low.
// R6: Bytes 1-3 hold pull-ups for ports 0, 1, 5; zero attaches.
// R7: Unused option bits read as one unless programmed to zero.
// R8: The programmer never writes zero into an unused option bit.
// R9: Erased bits are one; programming only clears bits.
// R10: EPROM mode looks like a 32 Kbyte byte-wide memory without signature mode.
// R11: Options are sampled during reset, latched, and held until the next reset. The code fetches them right after reset is released.
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`include "option_cfg.svh"

module otprom_option_decoder #(
    parameter int ADDR_W = 15,
    parameter int DATA_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // Array read port
    output option_pkg::prom_req_t prom_req,
    input wire logic [DATA_W-1:0] prom_rdata,
    // EPROM mode address mapping
    input wire logic eprom_mode,
    input wire logic [15:0] cpu_addr,
    output logic [ADDR_W-1:0] prom_addr_map,
    output logic prom_addr_hit,
    output logic signature_supported,
    // Decoded options
    output option_pkg::option_cfg_t options,
    output logic options_valid,
    // AXI4-Lite
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import option_pkg::*;

    // ----------------------------------------
    // Option load sequence
    // ----------------------------------------
    load_state_t state;
    load_state_t next_state;
    logic [2:0] idx;
    logic [DATA_W-1:0] raw [0:5];
    logic reload_req;
    wire last_byte = (idx == `OPT_COUNT - 3'h1);
    wire fetch = (state == ST_LOAD);

    // Bytes fetched after reset is released and again on each reload; decoded settings never move in run
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: next_state = ST_LOAD;
            ST_LOAD: next_state = last_byte ? ST_DONE : ST_LOAD;
            ST_DONE: next_state = reload_req ? ST_LOAD : ST_DONE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE; // R11
            idx <= 3'h0;
        end else if (clk_en) begin
            state <= next_state;
            if (fetch) begin
                idx <= last_byte ? 3'h0 : idx + 3'h1;
            end
        end
    end

    assign prom_req.valid = fetch;
    assign prom_req.addr = `OPT_FIRST_ADDR + {12'h000, idx}; // R1

    // Array data arrives on the same cycle; unprogrammed cells read all ones
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_raw
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    raw[g] <= `OPT_ERASED; // R9
                end else if (clk_en && fetch && idx == 3'(g)) begin
                    raw[g] <= prom_rdata; // R11
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            options <= '1; // R9
            options_valid <= 1'b0;
        end else if (clk_en && state == ST_DONE && !options_valid) begin
            options.por_enable <= raw[0][`OPT0_POR_BIT]; // R3
            options.dual_clock <= raw[0][`OPT0_DUAL_BIT]; // R4
            options.reset_pin_drive <= raw[0][`OPT0_RSTOUT_BIT]; // R5
            options.osc_settle_sel <= {raw[0][`OPT0_SETTLE_HI_BIT], raw[0][`OPT0_SETTLE_LO_BIT]}; // R3
            options.port0_pullup_n <= raw[1]; // R6
            options.port1_pullup_n <= raw[2]; // R6
            options.port5_pullup_n <= raw[3]; // R6
            options_valid <= 1'b1; // R11
        end
    end

    // ----------------------------------------
    // EPROM mode address map
    // ----------------------------------------
    wire in_window = (cpu_addr >= `CPU_WIN_BASE);
    wire [15:0] offset = cpu_addr - `CPU_WIN_BASE;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prom_addr_map <= '0;
            prom_addr_hit <= 1'b0;
        end else if (clk_en) begin
            prom_addr_map <= `PROG_WIN_LO + offset[ADDR_W-1:0]; // R2
            prom_addr_hit <= eprom_mode && in_window; // R2 R10
        end
    end
    assign signature_supported = 1'b0; // R10

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    logic aw_held;
    logic w_held;
    logic [11:0] aw_addr;
    logic ctrl_reload;
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    wire aw_go = s_axi_awvalid && s_axi_awready;
    wire w_go = s_axi_wvalid && s_axi_wready;
    wire aw_have = aw_held || aw_go;
    wire w_have = w_held || w_go;
    wire [11:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
    wire do_write = aw_have && w_have && !s_axi_bvalid;
    wire wr_ctrl = (wr_addr == `REG_CTRL) && s_axi_wstrb[0];

    // Reload refetches only the raw bytes; decoded options stay until the next reset
    assign reload_req = ctrl_reload;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            ctrl_reload <= `CTRL_RESET;
        end else if (clk_en) begin
            ctrl_reload <= 1'b0;
            if (aw_go) aw_addr <= s_axi_awaddr;
            aw_held <= aw_have && !do_write;
            w_held <= w_have && !do_write;
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_addr <= `REG_OPT5 && wr_addr[1:0] == 2'h0) ? `RESP_OKAY : `RESP_SLVERR;
                ctrl_reload <= wr_ctrl && s_axi_wdata[0] && !eprom_mode;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic [31:0] rd_word;
    logic rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            `REG_CTRL: rd_word = 32'h0000_0000;
            `REG_STATUS: rd_word = {29'h0, eprom_mode, state == ST_LOAD, options_valid};
            `REG_OPT0: rd_word = {24'h0, raw[0]}; // R7
            `REG_OPT1: rd_word = {24'h0, raw[1]};
            `REG_OPT2: rd_word = {24'h0, raw[2]};
            `REG_OPT3: rd_word = {24'h0, raw[3]};
            `REG_OPT4: rd_word = {24'h0, raw[4]}; // R7
            `REG_OPT5: rd_word = {24'h0, raw[5]}; // R7
            default: begin
                rd_word = 32'h0000_0000;
                rd_ok = 1'b0;
            end
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule : otprom_option_decoder

// file: option_decoder_sva.sv
// Port checker for the option decoder
`timescale 1ns/1ps
module option_decoder_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input option_pkg::prom_req_t prom_req,
    input wire logic [7:0] prom_rdata,
    input wire logic eprom_mode,
    input wire logic [15:0] cpu_addr,
    input wire logic [14:0] prom_addr_map,
    input wire logic prom_addr_hit,
    input wire logic signature_supported,
    input option_pkg::option_cfg_t options,
    input wire logic options_valid
);
    import option_pkg::*;
    logic [7:0] cap [4];
    wire cpu_hi = eprom_mode && cpu_addr >= 16'hC000;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Only the four decoded bytes are kept; low address bits pick the slot
    always_ff @(posedge aclk) begin
        if (prom_req.valid && prom_req.addr <= 15'h3FF3) begin
            cap[prom_req.addr[1:0]] <= prom_rdata;
        end
    end
    a_req_range: assert property (prom_req.valid |-> prom_req.addr inside {[15'h3FF0:15'h3FF5]})
        else $error("fetch outside option area");
    a_req_order: assert property ($rose(prom_req.valid) |->
        prom_req.addr == 15'h3FF0 ##1 prom_req.addr == 15'h3FF1 ##4 prom_req.addr == 15'h3FF5)
        else $error("option fetch order wrong");
    a_map_addr: assert property (clk_en && cpu_hi |=> prom_addr_map == $past(cpu_addr[14:0]))
        else $error("mapped address wrong");
    a_hit_flag: assert property (clk_en |=> prom_addr_hit == $past(cpu_hi))
        else $error("window hit wrong");
    a_sig_none: assert property (!signature_supported)
        else $error("signature mode offered");
    a_opt_hold: assert property (options_valid |=> options_valid && $stable(options))
        else $error("options changed after load");
    a_opt_erased: assert property (disable iff (1'b0) !aresetn && clk_en |=> &options && !options_valid)
        else $error("options not all ones in reset");
    a_opt_decode: assert property ($rose(options_valid) |->
        options == {cap[0][0], cap[0][1], cap[0][2], cap[0][5:4], cap[1], cap[2], cap[3]})
        else $error("decoded options wrong");
    c_loaded: cover property ($rose(options_valid));
    c_mapped: cover property (prom_addr_hit);
    c_reload: cover property (options_valid && prom_req.valid);
endmodule : option_decoder_sva

bind otprom_option_decoder option_decoder_sva chk (.aclk, .aresetn, .clk_en, .prom_req, .prom_rdata, .eprom_mode,
    .cpu_addr, .prom_addr_map, .prom_addr_hit, .signature_supported, .options, .options_valid);

// file: option_prom_model.sv
// Programmed option area model behind the array read port
`timescale 1ns/1ps
module option_prom_model (
    input option_pkg::prom_req_t prom_req,
    output logic [7:0] prom_rdata
);
    import option_pkg::*;
    logic [7:0] mem [6];
    wire in_opt = prom_req.addr inside {[15'h3FF0:15'h3FF5]};
    // Idle port shows the inverted low address byte so a stale sample cannot pass
    assign prom_rdata = !prom_req.valid ? ~prom_req.addr[7:0] :
        in_opt ? mem[3'(prom_req.addr - 15'h3FF0)] : 8'hFF;
    task automatic erase_all();
        foreach (mem[i]) mem[i] = 8'hFF;
    endtask : erase_all
    // Programming only clears bits, and never an unused one
    task automatic program_byte(input int i, input logic [7:0] v);
        mem[i] = mem[i] & (v | (i == 0 ? 8'hC8 : i > 3 ? 8'hFF : 8'h00));
    endtask : program_byte
endmodule : option_prom_model

// file: tb_otprom_option_decoder.sv
// Self-checking bench for the option decoder
`timescale 1ns/1ps
module tb_otprom_option_decoder;
    import option_pkg::*;
    logic aclk, aresetn, eprom_mode, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, prom_addr_hit;
    logic signature_supported, options_valid, clk_en;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [15:0] cpu_addr;
    logic [14:0] prom_addr_map;
    logic [7:0] prom_rdata;
    logic [7:0] e [6];
    logic [7:0] pv [6] = '{8'hD9, 8'h5A, 8'hA5, 8'h3C, 8'hFF, 8'hFF};
    logic [15:0] ca [3] = '{16'hC000, 16'hFFFF, 16'h8000};
    prom_req_t prom_req;
    option_cfg_t options;
    int n_mismatch = 0;
    int compares = 0;
    otprom_option_decoder uut (.aclk, .aresetn, .clk_en, .prom_req, .prom_rdata, .eprom_mode, .cpu_addr,
        .prom_addr_map, .prom_addr_hit, .signature_supported, .options, .options_valid, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    option_prom_model prom (.prom_req, .prom_rdata);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_opt();
        chk({3'h0, options}, {3'h0, e[0][0], e[0][1], e[0][2], e[0][5:4], e[1], e[2], e[3]});
    endtask : chk_opt
    // Ready levels are sampled at the edge, before the design updates
    task automatic wr(input logic [11:0] a, input logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= 32'h1;
        {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk(s_axi_bresp, r);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        chk(s_axi_rdata, d);
        chk(s_axi_rresp, r);
    endtask : rd
    task automatic test_done();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    initial begin
        repeat (5000) @(posedge aclk);
        n_mismatch++;
        test_done();
    end
    initial begin
        {aresetn, eprom_mode, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        {s_axi_bready, s_axi_rready, clk_en} = 3'h7;
        {cpu_addr, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        prom.erase_all();
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 6; i++) begin
                if (k == 1) prom.program_byte(i, pv[i]);
                e[i] = k ? pv[i] : 8'hFF;
            end
            if (k == 1) begin
                @(posedge aclk);
                aresetn <= 1'b0;
            end
            repeat (3) @(posedge aclk);
            aresetn <= 1'b1;
            do @(posedge aclk); while (!options_valid);
            chk_opt();
            for (int i = 0; i < 6; i++) rd(12'h008 + 12'(4 * i), {24'h0, e[i]}, 2'h0);
        end
        rd(12'h004, 32'h1, 2'h0);
        rd(12'h100, 32'h0, 2'h2);
        wr(12'h100, 2'h2);
        prom.program_byte(1, 8'h00);
        wr(12'h000, 2'h0);
        rd(12'h004, 32'h3, 2'h0);
        repeat (12) @(posedge aclk);
        chk_opt();
        rd(12'h00C, 32'h0, 2'h0);
        eprom_mode <= 1'b1;
        foreach (ca[j]) begin
            cpu_addr <= ca[j];
            repeat (2) @(posedge aclk);
            chk(prom_addr_hit, ca[j] >= 16'hC000);
            if (ca[j] >= 16'hC000) chk(prom_addr_map, ca[j][14:0]);
        end
        // Frozen enable must hold the hit flag
        clk_en <= 1'b0;
        cpu_addr <= 16'hC000;
        repeat (3) @(posedge aclk);
        chk(prom_addr_hit, 32'h0);
        clk_en <= 1'b1;
        repeat (2) @(posedge aclk);
        chk(prom_addr_hit, 32'h1);
        chk(signature_supported, 32'h0);
        wr(12'h000, 2'h0);
        rd(12'h004, 32'h5, 2'h0);
        test_done();
    end
endmodule : tb_otprom_option_decoder
